//--- watchdog_wakeup_reset_supervisor_test.sv
// Bench for the wake-up and reset supervisor
`default_nettype none
module watchdog_wakeup_reset_supervisor_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLK = 1'h0, RSTN = 1'h0, CE = 1'h1, REG_GOOD = 1'h0;
	logic SERVICE_PULSE_IN, RESET_N, WAKE_UP;
	logic [1:0] mode = 2'h0;
	logic [3:0] dly = 4'h5;
	int error_cnt = 0, num_checks = 0, n, seed = 32'h04a3e328;
	wdsv_supervisor #(.PERIOD_CYC(40), .DELAY_CYC(20), .PULSE_CYC(5)) i_wdsv_supervisor (.CLK(CLK), .RSTN(RSTN),
		.CE(CE), .REG_GOOD(REG_GOOD), .SERVICE_PULSE_IN(SERVICE_PULSE_IN), .RESET_N(RESET_N), .WAKE_UP(WAKE_UP));
	wdsv_cpu_model i_wdsv_cpu_model (.clk(CLK), .wake(WAKE_UP), .mode(mode), .dly(dly), .svc(SERVICE_PULSE_IN));
	initial forever #5 CLK = ~CLK;
	// ==========================================
	// Shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Counts falling edges until an output reaches a level
	task automatic wait_lvl(input bit w, input logic v, input int lim, output int k);
		k = 0;
		while (((w ? WAKE_UP : RESET_N) !== v) && k < lim) begin
			@(negedge CLK);
			k++;
		end
		// A limit that runs out counts as a mismatch
		check(32'(k < lim), 32'h1);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// ==========================================
	// Main sequence
	initial begin
		repeat (12) @(negedge CLK);
		RSTN = 1'h1;
		repeat (30) @(negedge CLK);
		check(RESET_N, 1'h0);
		mode = 2'h1;
		REG_GOOD = 1'h1;
		wait_lvl(0, 1'h1, 10, n);
		check(n <= 6, 1'h1);
		wait_lvl(1, 1'h1, 40, n);
		check(n inside {[19:22]}, 1'h1);
		$display("power-up done");
		for (int i = 0; i < 6; i++) begin
			wait_lvl(1, 1'h1, 60, n);
			wait_lvl(1, 1'h0, 25, n);
			check(n <= dly + 7, 1'h1);
			check(RESET_N, 1'h1);
			// New delay only while the model is idle, so it never races the model's read
			dly = 4'(($random(seed) & 7) + 3);
		end
		$display("prompt service done");
		mode = 2'h2;
		wait_lvl(1, 1'h0, 60, n);
		wait_lvl(1, 1'h1, 60, n);
		wait_lvl(1, 1'h0, 60, n);
		check(n, 20);
		wait_lvl(1, 1'h1, 60, n);
		check(n, 20);
		check(RESET_N, 1'h1);
		$display("late service done");
		mode = 2'h3;
		wait_lvl(0, 1'h0, 100, n);
		wait_lvl(0, 1'h1, 20, n);
		check(n inside {[5:6]}, 1'h1);
		wait_lvl(1, 1'h1, 40, n);
		check(n inside {[19:22]}, 1'h1);
		repeat (5) @(negedge CLK);
		mode = 2'h0;
		wait_lvl(0, 1'h0, 60, n);
		check(n inside {[30:42]}, 1'h1);
		$display("missed service done");
		mode = 2'h1;
		wait_lvl(1, 1'h1, 60, n);
		REG_GOOD = 1'h0;
		wait_lvl(0, 1'h0, 10, n);
		check(n <= 6, 1'h1);
		repeat (50) @(negedge CLK);
		check({RESET_N, WAKE_UP}, 2'h0);
		REG_GOOD = 1'h1;
		wait_lvl(0, 1'h1, 10, n);
		check(n <= 6, 1'h1);
		$display("regulation loss done");
		// Clock enable low freezes the start delay
		CE = 1'h0;
		repeat (10) @(negedge CLK);
		check({RESET_N, WAKE_UP}, 2'h2);
		CE = 1'h1;
		wait_lvl(1, 1'h1, 40, n);
		check(n, 20);
		$display("clock enable done");
		stop_test();
	end
	// Hang guard, about three times the planned run
	initial begin
		#20us;
		error_cnt++;
		stop_test();
	end
endmodule
`default_nettype wire

//--- wdsv_cpu_model.sv
// Processor model that answers wake-up pulses on the service line
`default_nettype none
module wdsv_cpu_model (
	input wire logic clk,
	input wire logic wake,
	input wire logic [1:0] mode,
	input wire logic [3:0] dly,
	output logic svc
);
	timeunit 1ns;
	timeprecision 1ps;
	logic drv = 1'h1;
	logic wake_q = 1'h0;
	// Mode 3 holds the line low as a plain level
	assign svc = drv & (mode != 2'h3);
	// ==========================================
	// Service pulse generator
	// one falling edge, long phases
	initial begin
		forever begin
			@(negedge clk);
			if ((mode == 2'h1 && wake && !wake_q) || (mode == 2'h2 && !wake && wake_q)) begin
				repeat (dly) @(negedge clk);
				drv = 1'h0;
				repeat (4) @(negedge clk);
				drv = 1'h1;
			end
			wake_q = wake;
		end
	end
endmodule
`default_nettype wire

//--- wdsv_pkg.sv
// Package of constants and types for the wake-up and reset supervisor
`default_nettype none
package wdsv_pkg;
	// ==========================================
	// Clock and timing figures
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned WAKE_PERIOD_MS = 40;
	localparam int unsigned WAKE_DELAY_MS = 20;
	localparam int unsigned POR_DELAY_MS = 5;
	localparam int unsigned NS_PER_MS = 1000000;
	// Cycle counts derived from the figures
	localparam int unsigned WAKE_PERIOD_CYC = WAKE_PERIOD_MS * (NS_PER_MS / CLK_PERIOD_NS);
	localparam int unsigned WAKE_HALF_CYC = WAKE_PERIOD_CYC / 2;
	localparam int unsigned WAKE_DELAY_CYC = WAKE_DELAY_MS * (NS_PER_MS / CLK_PERIOD_NS);
	localparam int unsigned POR_DELAY_CYC = POR_DELAY_MS * (NS_PER_MS / CLK_PERIOD_NS);
	localparam int unsigned CNT_W = 24;
	// Reset values of the outputs
	localparam logic RST_N_INIT = 1'h0;
	localparam logic WAKE_INIT = 1'h0;
	// ==========================================
	// Supervisor states
	typedef enum logic [1:0] {
		ST_HOLD,
		ST_PULSE,
		ST_DELAY,
		ST_RUN
	} wdsv_state_t;
endpackage
`default_nettype wire

//--- wdsv_supervisor.sv
// Wake-up generator, watchdog edge monitor and reset supervisor
`default_nettype none
// Notes on behaviour
// RULE1: Only falling service input edges count.
// RULE2: Processor gives a falling edge each period.
// RULE3: Service edge drives wake-up low at once.
// RULE4: Reset held low until regulation good.
// RULE5: Regulation loss asserts reset until restored.
// RULE6: Missed service edge gives a reset pulse.
// RULE7: Wake-up output toggles continuously.
// RULE8: All timings share one timebase unit.
// RULE9: Wake-up period nominally 40 ms.
// RULE10: Wake-up duty cycle 50 percent.
// RULE11: First wake-up rise 20 ms after reset.
// RULE12: Service input phases last at least 5 us.
// RULE13: Reset release restarts watchdog window.
module wdsv_supervisor #(
	parameter int unsigned TICK_DIV = 1,
	parameter int unsigned PERIOD_CYC = wdsv_pkg::WAKE_PERIOD_CYC,
	parameter int unsigned DELAY_CYC = wdsv_pkg::WAKE_DELAY_CYC,
	parameter int unsigned PULSE_CYC = wdsv_pkg::POR_DELAY_CYC
) (
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic CE,
	input wire logic REG_GOOD,
	input wire logic SERVICE_PULSE_IN,
	output logic RESET_N,
	output logic WAKE_UP
);
	// ==========================================
	// State record
	typedef struct packed {
		logic [2:0] sync;
		logic [2:0] rg_sync;
		logic svc_prev;
		logic [wdsv_pkg::CNT_W-1:0] tick;
		logic [wdsv_pkg::CNT_W-1:0] phase;
		logic [wdsv_pkg::CNT_W-1:0] window;
		logic serviced;
		logic half; // Set during the high half of the wake-up period
		wdsv_pkg::wdsv_state_t st;
		logic rst_n;
		logic wake;
	} wdsv_regs_t;

	wdsv_regs_t r;
	wdsv_regs_t next_r;
	logic svc_fall;
	logic rg_ok;
	logic tick_en;

	// Count compare against a cycle figure
	function automatic logic reached(input logic [wdsv_pkg::CNT_W-1:0] c, input int unsigned lim);
		reached = (c >= wdsv_pkg::CNT_W'(lim - 1));
	endfunction

	// ==========================================
	// Next-state logic
	always_comb begin
		next_r = r;
		// Three-stage synchronisers, stages two and three must agree
		next_r.sync = {r.sync[1:0], SERVICE_PULSE_IN};
		next_r.rg_sync = {r.rg_sync[1:0], REG_GOOD};
		if (r.sync[2] == r.sync[1]) begin
			next_r.svc_prev = r.sync[2];
		end
		// RULE1: falling edge only
		svc_fall = (r.sync[2] == r.sync[1]) && r.svc_prev && !r.sync[2];
		// While stages two and three disagree, keep the level that reset shows now
		rg_ok = (r.rg_sync[2] == r.rg_sync[1]) ? r.rg_sync[2] : r.rst_n;
		// RULE8: one shared timebase tick
		tick_en = reached(r.tick, TICK_DIV);
		next_r.tick = tick_en ? '0 : r.tick + 1'b1;
		case (r.st)
			wdsv_pkg::ST_HOLD: begin
				// RULE4: held while regulation bad
				// RULE5: held until restored
				next_r.rst_n = 1'b0;
				next_r.wake = 1'b0;
				if (rg_ok) begin
					next_r.st = wdsv_pkg::ST_DELAY;
					next_r.rst_n = 1'b1;
					next_r.phase = '0;
				end
			end
			wdsv_pkg::ST_PULSE: begin
				// RULE6: timed reset pulse
				next_r.rst_n = 1'b0;
				next_r.wake = 1'b0;
				if (!rg_ok) begin
					next_r.st = wdsv_pkg::ST_HOLD;
				end else if (tick_en) begin
					next_r.phase = r.phase + 1'b1;
					if (reached(r.phase, PULSE_CYC)) begin
						next_r.st = wdsv_pkg::ST_DELAY;
						next_r.rst_n = 1'b1;
						next_r.phase = '0;
					end
				end
			end
			wdsv_pkg::ST_DELAY: begin
				// RULE11: delay to first wake-up rise
				if (!rg_ok) begin
					next_r.st = wdsv_pkg::ST_HOLD;
					next_r.rst_n = 1'b0;
				end else if (tick_en) begin
					next_r.phase = r.phase + 1'b1;
					if (reached(r.phase, DELAY_CYC)) begin
						// RULE13: fresh window at start
						next_r.st = wdsv_pkg::ST_RUN;
						next_r.wake = 1'b1;
						next_r.phase = '0;
						next_r.window = '0;
						next_r.serviced = 1'b0;
						next_r.half = 1'b1;
					end
				end
			end
			wdsv_pkg::ST_RUN: begin
				if (!rg_ok) begin
					next_r.st = wdsv_pkg::ST_HOLD;
					next_r.rst_n = 1'b0;
					next_r.wake = 1'b0;
				end else begin
					if (svc_fall) begin
						next_r.serviced = 1'b1;
					end
					if (tick_en) begin
						// RULE7: free-running wake-up toggle
						// RULE9: period count
						// RULE10: half period each phase
						next_r.phase = r.phase + 1'b1;
						if (reached(r.phase, PERIOD_CYC / 2)) begin
							next_r.phase = '0;
							// High half opens with a rise, low half with a fall
							next_r.half = !r.half;
							next_r.wake = !r.half;
						end
						next_r.window = r.window + 1'b1;
						if (reached(r.window, PERIOD_CYC)) begin
							next_r.window = '0;
							next_r.serviced = 1'b0;
							// RULE6: missed service, pulse reset
							if (!(r.serviced || svc_fall)) begin
								next_r.st = wdsv_pkg::ST_PULSE;
								next_r.rst_n = 1'b0;
								next_r.wake = 1'b0;
								next_r.phase = '0;
							end
						end
					end
					// Service drop comes last so it wins over a toggle in the same tick
					// RULE3: wake-up falls on service
					if (svc_fall) begin
						next_r.wake = 1'b0;
					end
				end
			end
			default: begin
				next_r.st = wdsv_pkg::ST_HOLD;
			end
		endcase
	end

	// ==========================================
	// State register with synchronous reset and clock enable
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			r <= '0;
			r.st <= wdsv_pkg::ST_HOLD;
			r.rst_n <= wdsv_pkg::RST_N_INIT;
			r.wake <= wdsv_pkg::WAKE_INIT;
		end else if (CE) begin
			r <= next_r;
		end
	end

	// Outputs straight from the state flops
	assign RESET_N = r.rst_n;
	assign WAKE_UP = r.wake;

	// ==========================================
	// Checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN || !CE);

	// RULE3: service edge drops wake-up
	svc_drops_wake_a: assert property ((r.st == wdsv_pkg::ST_RUN) && rg_ok && svc_fall |=> !WAKE_UP) // RULE3
		else $error("wake-up did not fall after service edge");
	// RULE4: hold state keeps reset low
	hold_low_a: assert property ((r.st == wdsv_pkg::ST_HOLD) |-> !RESET_N) // RULE4
		else $error("reset high while holding");
	// RULE5: regulation loss asserts reset
	reg_loss_a: assert property ((r.st != wdsv_pkg::ST_HOLD) && !rg_ok |=> !RESET_N) // RULE5
		else $error("reset not asserted on regulation loss");
	// RULE6: missed window starts pulse
	miss_pulse_a: assert property ((r.st == wdsv_pkg::ST_RUN) && rg_ok && tick_en // RULE6
		&& reached(r.window, PERIOD_CYC) && !r.serviced && !svc_fall |=> !RESET_N)
		else $error("no reset after missed service");
	// RULE1: rising input never services
	rise_ignored_a: assert property ((r.st == wdsv_pkg::ST_RUN) && rg_ok && !svc_fall && !r.serviced // RULE1
		|=> !r.serviced)
		else $error("service taken without a falling edge");
	// RULE11: wake-up low during delay
	delay_low_a: assert property ((r.st == wdsv_pkg::ST_DELAY) |-> !WAKE_UP && RESET_N) // RULE11
		else $error("wake-up high during start delay");
	// RULE13: run entry starts fresh window
	fresh_win_a: assert property ($rose(r.st == wdsv_pkg::ST_RUN) |-> r.window == '0 && WAKE_UP) // RULE13
		else $error("window not restarted");
	// RULE10: phase counter bounded by half period
	half_bound_a: assert property ((r.st == wdsv_pkg::ST_RUN) |-> r.phase < wdsv_pkg::CNT_W'(PERIOD_CYC / 2)) // RULE10
		else $error("wake-up phase overran half period");
	// RULE9: rises only open a high half
	wake_rise_a: assert property ($rose(WAKE_UP) |-> r.half && (r.st == wdsv_pkg::ST_RUN)) // RULE9
		else $error("wake-up rose outside a high half");

	// Main scenarios
	run_c: cover property (r.st == wdsv_pkg::ST_RUN ##1 svc_fall);
	pulse_c: cover property (r.st == wdsv_pkg::ST_PULSE);
	regloss_c: cover property ((r.st == wdsv_pkg::ST_RUN) ##1 (r.st == wdsv_pkg::ST_HOLD));
	restart_c: cover property ((r.st == wdsv_pkg::ST_PULSE) ##1 (r.st == wdsv_pkg::ST_DELAY));
	freeze_c: cover property ($rose(CE) && (r.st == wdsv_pkg::ST_DELAY));
endmodule
`default_nettype wire
